/* lcdc_ctrl.sv */
/*
  Segment LCD control: voltage source and bias selection, display clock
  prescaler, common phase sequencing and per-segment level selection.
  Assumes the analog drivers turn level codes into V1..V5 and that the
  display memory is held by the surrounding logic on the system clock.
*/
// Overview of operation
// - Each memory bit drives one segment; a set bit turns it on.
// - Segment gate ANDs every memory bit; gate low blanks, timing continues.
// - Internal voltage generation off when oscillator off or master off.
// - Supply source when not external, level zero and reference zero.
// - Charge pump source when not external, pump enabled, level nonzero.
// - Pump disabled with nonzero level holds capacitor voltage until re-enabled.
// - Reference code 01 uses external reference pin; level field ignored.
// - External select takes voltage from capacitor pin; pump kept off.
// - External bias select disables internal bias generation.
// - V5 external select stops generating the lowest level internally.
// - Switched pin drives out when bias is external and voltage is not external, is input otherwise.
// - Multiplexed modes use half bias when selected, else third bias.
// - Static mode disables the internal bias divider always.
// - Line timing comes from a display clock divided from auxiliary clock.
// - Divider select picks display rate; software sets 2*mux*frame rate.
// - Mux field: 00 static, 01 2-mux, 10 3-mux, 11 4-mux.
// - Each higher mux rate adds one common and one segment per output.
// - Master on starts timing and switched output; off stops both.
`timescale 1ns/1ps
module lcdc_ctrl #(
  parameter int unsigned NUM_SEG = 8
) (
  input  wire logic                     clk_i,             // System clock
  input  wire logic                     rstn_i,            // Async reset, active low
  input  wire logic                     aclk_i,            // Auxiliary clock pin
  input  wire lcdc_pkg::lcdc_cfg_t      cfg_i,             // Control bits
  input  wire logic [NUM_SEG*4-1:0]     seg_mem_i,         // Display memory bits
  output lcdc_pkg::lcdc_volt_t          volt_o,            // Voltage block controls
  output logic [3:0][2:0]               com_lv_o,          // Common line levels
  output logic [NUM_SEG-1:0][2:0]       seg_lv_o,          // Segment line levels
  output logic                          vlcd_switched_o,   // Switched pin value
  output logic                          vlcd_switched_oe_o // Switched pin enable
);
  import lcdc_pkg::*;

  logic       aclk_s1_q, aclk_s2_q, aclk_s3_q;
  logic       aclk_tick;
  logic [9:0] pre_q;
  logic [9:0] div_len;
  logic       dclk_tick;
  logic [1:0] com_q;
  logic       pol_q;
  logic [1:0] mux_last;
  logic       run;
  logic       gen_on;
  logic       pump_req;
  logic       ext_ref;
  logic       third;
  lcdc_volt_t volt_d;
  logic [3:0][2:0] com_d;

  assign run      = cfg_i.lcd_master_on;
  assign mux_last = cfg_i.mux_rate_field;
  assign gen_on   = cfg_i.lcd_master_on && !cfg_i.aclk_osc_off;
  assign ext_ref  = (cfg_i.pump_reference_select == LCDC_REF_EXTPIN);
  assign pump_req = cfg_i.charge_pump_enable &&
                    ((cfg_i.pump_voltage_level != 4'h0) || ext_ref);
  assign third    = !cfg_i.half_bias_select;

  // Auxiliary clock is asynchronous, so two stages before the edge detector
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aclk_s1_q <= 1'b0;
      aclk_s2_q <= 1'b0;
      aclk_s3_q <= 1'b0;
    end else begin
      aclk_s1_q <= aclk_i;
      aclk_s2_q <= aclk_s1_q;
      aclk_s3_q <= aclk_s2_q;
    end
  end
  assign aclk_tick = aclk_s2_q && !aclk_s3_q;

  // Display clock prescaler counts auxiliary rising edges
  assign div_len   = LCDC_DIV_TAB[cfg_i.frame_clock_divider_select];
  assign dclk_tick = aclk_tick && (pre_q >= div_len - 10'h001);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_q <= 10'h000;
    end else if (!run) begin
      pre_q <= 10'h000;
    end else if (dclk_tick) begin
      pre_q <= 10'h000;
    end else if (aclk_tick) begin
      pre_q <= pre_q + 10'h001;
    end
  end

  // Common phase and polarity; a frame is two passes over the commons
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      com_q <= 2'h0;
      pol_q <= 1'b0;
    end else if (!run) begin
      com_q <= 2'h0;
      pol_q <= 1'b0;
    end else if (dclk_tick) begin
      if (com_q >= mux_last) begin
        com_q <= 2'h0;
        pol_q <= !pol_q;
      end else begin
        com_q <= com_q + 2'h1;
      end
    end
  end

  // Voltage source and bias selection; pump, bias and V5 enables gated off with the generator
  always_comb begin
    volt_d              = '0;
    volt_d.gen_on       = gen_on;
    volt_d.pump_run     = gen_on && !cfg_i.vlcd_external_select && pump_req;
    volt_d.pump_ext_ref = volt_d.pump_run && ext_ref;
    volt_d.pump_level   = ext_ref ? 4'h0 : cfg_i.pump_voltage_level;
    if (cfg_i.vlcd_external_select) begin
      volt_d.src = LCDC_SRC_EXT;
    end else if (pump_req) begin
      volt_d.src = LCDC_SRC_PUMP;
    end else if ((cfg_i.pump_voltage_level == 4'h0) && (cfg_i.pump_reference_select == 2'h0)) begin
      volt_d.src = LCDC_SRC_AVCC;
    end else begin
      volt_d.src = LCDC_SRC_HOLD;
    end
    volt_d.bias_int_en  = gen_on && !cfg_i.external_bias_select &&
                          (cfg_i.mux_rate_field != LCDC_MUX_STATIC);
    volt_d.bias_half    = volt_d.bias_int_en && cfg_i.half_bias_select;
    volt_d.v5_int_en    = gen_on && !cfg_i.v5_external_select;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      volt_o <= '0;
    end else begin
      volt_o <= volt_d;
    end
  end

  // Switched display voltage only faces the pin while the ladder is external
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vlcd_switched_o    <= 1'b0;
      vlcd_switched_oe_o <= 1'b0;
    end else begin
      vlcd_switched_oe_o <= cfg_i.external_bias_select && !cfg_i.vlcd_external_select;
      vlcd_switched_o    <= run;
    end
  end

  // Common levels: selected at the extreme, other active ones at the mid levels, unused ones at V5
  always_comb begin
    com_d = {LCDC_NUM_COM{LCDC_LV_V5}};
    for (int c = 0; c < LCDC_NUM_COM; c++) begin
      if (run && (2'(c) <= mux_last)) begin
        if (2'(c) == com_q) begin
          com_d[c] = pol_q ? LCDC_LV_V1 : LCDC_LV_V5;
        end else if (third) begin
          com_d[c] = pol_q ? LCDC_LV_V4 : LCDC_LV_V2;
        end else begin
          com_d[c] = LCDC_LV_V3;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      com_lv_o <= {LCDC_NUM_COM{LCDC_LV_V5}};
    end else begin
      com_lv_o <= com_d;
    end
  end

  // Segment levels from the gated memory bit of the active common
  for (genvar s = 0; s < NUM_SEG; s++) begin : g_seg
    logic on_bit;
    assign on_bit = seg_mem_i[s*4 + int'(com_q)] && cfg_i.segments_on_gate;
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        seg_lv_o[s] <= LCDC_LV_V5;
      end else if (!run) begin
        seg_lv_o[s] <= LCDC_LV_V5;
      end else if (on_bit) begin
        seg_lv_o[s] <= pol_q ? LCDC_LV_V5 : LCDC_LV_V1;
      end else if (third && (cfg_i.mux_rate_field != LCDC_MUX_STATIC)) begin
        seg_lv_o[s] <= pol_q ? LCDC_LV_V2 : LCDC_LV_V4;
      end else begin
        seg_lv_o[s] <= pol_q ? LCDC_LV_V1 : LCDC_LV_V5;
      end
    end
  end

  // Checks
  // Static checks wait for the phase to wrap to common zero after a mux drop
  sequence s_static_blank;
    run && !cfg_i.segments_on_gate && (cfg_i.mux_rate_field == LCDC_MUX_STATIC) &&
      (com_q == 2'h0);
  endsequence

  sequence s_static_lit;
    run && cfg_i.segments_on_gate && seg_mem_i[0] &&
      (cfg_i.mux_rate_field == LCDC_MUX_STATIC) && (com_q == 2'h0);
  endsequence

  a_gen_disable: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!cfg_i.lcd_master_on || cfg_i.aclk_osc_off) |=>
      (!volt_o.gen_on && !volt_o.pump_run && !volt_o.bias_int_en))
    else $error("voltage generation active while disabled");

  a_src_supply: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!cfg_i.vlcd_external_select && !cfg_i.charge_pump_enable &&
     cfg_i.pump_voltage_level == 4'h0 && cfg_i.pump_reference_select == 2'h0)
      |=> volt_o.src == LCDC_SRC_AVCC)
    else $error("supply source not selected");

  a_src_pump: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (gen_on && !cfg_i.vlcd_external_select && cfg_i.charge_pump_enable &&
     cfg_i.pump_voltage_level != 4'h0)
      |=> (volt_o.src == LCDC_SRC_PUMP && volt_o.pump_run))
    else $error("pump source not running");

  a_pump_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!cfg_i.vlcd_external_select && !cfg_i.charge_pump_enable &&
     cfg_i.pump_voltage_level != 4'h0)
      |=> (volt_o.src == LCDC_SRC_HOLD && !volt_o.pump_run))
    else $error("paused pump not holding");

  a_ext_ref: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (cfg_i.pump_reference_select == LCDC_REF_EXTPIN) |=>
      (volt_o.pump_level == 4'h0 && volt_o.pump_ext_ref == volt_o.pump_run))
    else $error("external reference not honoured");

  a_ext_vlcd: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cfg_i.vlcd_external_select |=>
      (volt_o.src == LCDC_SRC_EXT && !volt_o.pump_run && !vlcd_switched_oe_o))
    else $error("external display voltage not taken");

  a_bias_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (cfg_i.external_bias_select || cfg_i.mux_rate_field == LCDC_MUX_STATIC)
      |=> !volt_o.bias_int_en)
    else $error("internal bias divider left on");

  a_frame_flip: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (run && dclk_tick && com_q == mux_last) ##1 run |->
      (pol_q != $past(pol_q) && com_q == 2'h0))
    else $error("polarity did not flip at end of pass");

  // A shorter divider may leave a stale count until the next auxiliary edge
  a_presc_range: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (run && aclk_tick) ##1 $stable(cfg_i.frame_clock_divider_select) |-> pre_q < div_len)
    else $error("prescaler ran past divider length");

  a_blank_seg: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_static_blank ##1 s_static_blank |-> seg_lv_o[0] == com_lv_o[0])
    else $error("blanked segment not matching common");

  a_lit_seg: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_static_lit ##1 s_static_lit |-> (seg_lv_o[0] != com_lv_o[0]))
    else $error("lit segment matches common");

endmodule

/* lcdc_ctrl_tb.sv */
/*
  Self-checking bench for the segment LCD control block.
  Assumes an auxiliary clock of ten system clocks, made here.
*/
`timescale 1ns/1ps
module lcdc_ctrl_tb;
  import lcdc_pkg::*;
  localparam int unsigned NS = 2;
  localparam lcdc_cfg_t BASE = '{lcd_master_on: 1'b1, segments_on_gate: 1'b1,
    charge_pump_enable: 1'b1, pump_voltage_level: 4'h5, mux_rate_field: LCDC_MUX_4,
    default: '0};
  logic             clk_i, rstn_i, aclk_i, clr, sw, sw_oe, bad;
  lcdc_cfg_t        cfg;
  lcdc_volt_t       volt;
  logic [NS*4-1:0]  mem, lit;
  logic [3:0][2:0]  com_lv;
  logic [NS-1:0][2:0] seg_lv;
  int               n_mismatch, check_count, acnt;

  lcdc_ctrl #(.NUM_SEG(NS)) lcdc_ctrl_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .aclk_i(aclk_i), .cfg_i(cfg), .seg_mem_i(mem), .volt_o(volt), .com_lv_o(com_lv),
    .seg_lv_o(seg_lv), .vlcd_switched_o(sw), .vlcd_switched_oe_o(sw_oe));
  lcdc_glass #(.NS(NS)) lcdc_glass_inst (.clk_i(clk_i), .clr_i(clr),
    .mux_i(cfg.mux_rate_field), .half_i(cfg.half_bias_select), .com_lv_i(com_lv),
    .seg_lv_i(seg_lv), .lit_o(lit), .bad_o(bad));

  // System clock, and an auxiliary clock slow enough for the synchroniser
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    acnt <= (acnt == 4) ? 0 : acnt + 1;
    if (acnt == 4) aclk_i <= ~aclk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Three edges leave room for the one-cycle register lag
  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic restore();
    @(posedge clk_i);
    cfg <= BASE;
  endtask

  task automatic volt_case(input logic ext, pen, input logic [3:0] lv,
                           input logic [1:0] rf, input lcdc_src_t src, input logic run);
    @(posedge clk_i);
    cfg.vlcd_external_select <= ext;
    cfg.charge_pump_enable <= pen;
    cfg.pump_voltage_level <= lv;
    cfg.pump_reference_select <= rf;
    settle();
    chk(volt.src, src);
    chk(volt.pump_run, run);
    chk(volt.pump_ext_ref, rf == LCDC_REF_EXTPIN);
    chk(volt.pump_level, (rf == LCDC_REF_EXTPIN) ? 4'h0 : lv);
    chk(volt.gen_on, 1'b1);
  endtask

  task automatic t_bias();
    @(posedge clk_i);
    cfg.half_bias_select <= 1'b1;
    cfg.v5_external_select <= 1'b1;
    settle();
    chk({volt.bias_half, volt.bias_int_en}, 2'h3);
    chk({volt.v5_int_en, sw_oe}, 2'h0);
    @(posedge clk_i);
    cfg.external_bias_select <= 1'b1;
    cfg.v5_external_select <= 1'b0;
    settle();
    chk({volt.bias_int_en, volt.v5_int_en}, 2'h1);
    chk({sw_oe, sw}, 2'h3);
    @(posedge clk_i);
    cfg.vlcd_external_select <= 1'b1;
    settle();
    chk({sw_oe, volt.pump_run}, 2'h0);
  endtask

  // Waits for the next change on the first common, counting clocks
  task automatic wait_flip(output int n);
    logic [2:0] lv;
    lv = com_lv[0];
    n = 0;
    while (com_lv[0] === lv) begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 12000) begin
        n_mismatch++;
        $display("mismatch at %0t: display timing stalled", $time);
        wrap_up();
      end
    end
  endtask

  task automatic t_rate(input logic [2:0] sel, input int exp);
    int n;
    @(posedge clk_i);
    cfg.frame_clock_divider_select <= sel;
    cfg.mux_rate_field <= LCDC_MUX_STATIC;
    repeat (3) wait_flip(n);
    check_count++;
    if (n < exp - 1 || n > exp + 1) begin
      n_mismatch++;
      $display("mismatch at %0t: tick period %0d", $time, n);
    end
  endtask

  // One settling frame, then one observed frame on the glass
  task automatic t_frame(input logic [1:0] mx, input logic hb, gt,
                         input logic [NS*4-1:0] mv);
    int fr;
    logic [NS*4-1:0] exp;
    fr = 2 * (mx + 1) * 320 + 40;
    @(posedge clk_i);
    cfg.mux_rate_field <= mx;
    cfg.half_bias_select <= hb;
    cfg.segments_on_gate <= gt;
    mem <= mv;
    repeat (fr) @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (fr) @(posedge clk_i);
    #1;
    for (int i = 0; i < NS * 4; i++) exp[i] = gt && mv[i] && ((i % 4) <= mx);
    chk(lit, exp);
    chk(bad, 1'b0);
    if (mx == LCDC_MUX_STATIC) chk(volt.bias_int_en, 1'b0);
  endtask

  task automatic t_off();
    @(posedge clk_i);
    cfg.aclk_osc_off <= 1'b1;
    settle();
    chk({volt.gen_on, volt.pump_run, volt.bias_int_en}, 3'h0);
    @(posedge clk_i);
    cfg.aclk_osc_off <= 1'b0;
    cfg.lcd_master_on <= 1'b0;
    settle();
    chk({volt.gen_on, sw}, 2'h0);
    chk(com_lv, {4{LCDC_LV_V5}});
    chk(seg_lv, {NS{LCDC_LV_V5}});
  endtask

  initial begin
    rstn_i = 1'b0;
    aclk_i = 1'b0;
    acnt = 0;
    clr = 1'b0;
    mem = '0;
    n_mismatch = 0;
    check_count = 0;
    cfg = BASE;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    volt_case(1'b0, 1'b0, 4'h0, 2'h0, LCDC_SRC_AVCC, 1'b0);
    volt_case(1'b0, 1'b1, 4'h5, 2'h0, LCDC_SRC_PUMP, 1'b1);
    volt_case(1'b0, 1'b0, 4'h5, 2'h0, LCDC_SRC_HOLD, 1'b0);
    volt_case(1'b1, 1'b1, 4'h5, 2'h0, LCDC_SRC_EXT, 1'b0);
    volt_case(1'b0, 1'b1, 4'h0, LCDC_REF_EXTPIN, LCDC_SRC_PUMP, 1'b1);
    restore();
    t_bias();
    restore();
    t_rate(3'h0, 320);
    t_rate(3'h7, 5120);
    restore();
    // Bit zero set in the static pass so the lit-segment check sees traffic
    for (int m = 0; m < 4; m++) begin
      for (int h = 0; h < 2; h++) begin
        t_frame(m[1:0], h[0], 1'b1, 8'h5B ^ 8'(m * 37));
      end
    end
    t_frame(LCDC_MUX_4, 1'b0, 1'b0, 8'hFF);
    t_frame(LCDC_MUX_STATIC, 1'b0, 1'b0, 8'hFF);
    t_off();
    wrap_up();
  end
endmodule

/* lcdc_glass.sv */
/*
  Passive segment glass: latches every pixel that sees a full V1-V5 swing.
  Assumes common and segment level codes are registered and aligned.
*/
`timescale 1ns/1ps
module lcdc_glass #(
  parameter int unsigned NS = 2
) (
  input  wire logic               clk_i,    // System clock
  input  wire logic               clr_i,    // Forget history
  input  wire logic [1:0]         mux_i,    // Mux field in use
  input  wire logic               half_i,   // Half bias in use
  input  wire logic [3:0][2:0]    com_lv_i, // Common levels
  input  wire logic [NS-1:0][2:0] seg_lv_i, // Segment levels
  output logic      [NS*4-1:0]    lit_o,    // Pixels driven on
  output logic                    bad_o     // Illegal level seen
);
  import lcdc_pkg::*;
  logic bad_now;

  // Levels that a glass of this bias may legally see
  function automatic logic ok(input logic [2:0] v);
    return v == LCDC_LV_V1 || v == LCDC_LV_V5 || (mux_i != 2'h0 &&
           (half_i ? v == LCDC_LV_V3 : (v == LCDC_LV_V2 || v == LCDC_LV_V4)));
  endfunction

  // Only a full swing darkens; commons above the mux count are not wired
  always_ff @(posedge clk_i) begin
    for (int s = 0; s < NS; s++) begin
      for (int c = 0; c < 4; c++) begin
        if (clr_i) begin
          lit_o[s*4+c] <= 1'b0;
        end else if (c <= mux_i && (com_lv_i[c] ^ seg_lv_i[s]) == 3'h4) begin
          lit_o[s*4+c] <= 1'b1;
        end
      end
    end
  end

  // Any out-of-set level on a wired line is remembered until cleared
  always_comb begin
    bad_now = 1'b0;
    for (int c = 0; c < 4; c++) if (c <= mux_i && !ok(com_lv_i[c])) bad_now = 1'b1;
    for (int s = 0; s < NS; s++) if (!ok(seg_lv_i[s])) bad_now = 1'b1;
  end
  always_ff @(posedge clk_i) bad_o <= !clr_i && (bad_o || bad_now);
endmodule

/* lcdc_pkg.sv */
/*
  Shared constants and carrier types for the segment LCD control block.
  Assumes a single 25 MHz system clock and an auxiliary clock near 32768 Hz.
*/
package lcdc_pkg;

  // System clock and auxiliary clock rates
  localparam int unsigned LCDC_CLK_HZ  = 25000000;
  localparam int unsigned LCDC_ACLK_HZ = 32768;

  // Output level codes, V1 is the peak, V5 the lowest
  localparam logic [2:0] LCDC_LV_V1 = 3'h0;
  localparam logic [2:0] LCDC_LV_V2 = 3'h1;
  localparam logic [2:0] LCDC_LV_V3 = 3'h2;
  localparam logic [2:0] LCDC_LV_V4 = 3'h3;
  localparam logic [2:0] LCDC_LV_V5 = 3'h4;

  // Mux rate field codes
  localparam logic [1:0] LCDC_MUX_STATIC = 2'h0;
  localparam logic [1:0] LCDC_MUX_2      = 2'h1;
  localparam logic [1:0] LCDC_MUX_3      = 2'h2;
  localparam logic [1:0] LCDC_MUX_4      = 2'h3;

  // Reference select code that routes the external reference pin to the pump
  localparam logic [1:0] LCDC_REF_EXTPIN = 2'h1;

  // Commons and memory bits per segment output
  localparam int unsigned LCDC_NUM_COM = 4;

  // Auxiliary clock periods per display clock, indexed by the divider select
  localparam logic [7:0][9:0] LCDC_DIV_TAB = {10'h200, 10'h180, 10'h100, 10'h0C0,
                                              10'h080, 10'h060, 10'h040, 10'h020};

  // Where the display voltage comes from
  typedef enum logic [1:0] {
    LCDC_SRC_AVCC,
    LCDC_SRC_PUMP,
    LCDC_SRC_HOLD,
    LCDC_SRC_EXT
  } lcdc_src_t;

  // Software control bits
  typedef struct packed {
    logic       lcd_master_on;
    logic       segments_on_gate;
    logic       aclk_osc_off;
    logic       vlcd_external_select;
    logic       charge_pump_enable;
    logic [3:0] pump_voltage_level;
    logic [1:0] pump_reference_select;
    logic       external_bias_select;
    logic       v5_external_select;
    logic       half_bias_select;
    logic [1:0] mux_rate_field;
    logic [2:0] frame_clock_divider_select;
  } lcdc_cfg_t;

  // Controls for the analog voltage and bias blocks
  typedef struct packed {
    logic       gen_on;
    logic       pump_run;
    logic       pump_ext_ref;
    logic [3:0] pump_level;
    lcdc_src_t  src;
    logic       bias_int_en;
    logic       bias_half;
    logic       v5_int_en;
  } lcdc_volt_t;

endpackage
